// [hw/cptx_top.sv]
// transmit coding path: idle deletion, 65-bit block encoder, forty bit check
`timescale 1ns/1ps
`include "cptx_params.svh"
module cptx_top
   import cptx_pkg::*;
#(
   parameter int DELAY_LINE_BLOCKS = 29
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic clk_en_i,
   input wire logic [71:0] raw_vec_i,
   input wire logic raw_valid_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   output logic [71:0] raw_out_o,
   output logic raw_out_valid_o,
   output logic [64:0] block_o,
   output logic block_valid_o,
   output logic codeword_start_o,
   output logic [39:0] check_o,
   output logic check_valid_o,
   output logic [7:0] pad_bits_o,
   output logic [11:0] parity_bits_o,
   output logic burst_end_o,
   output logic begin_o
);
   // byte lane k of a two-transfer raw vector
   function automatic logic [7:0] lane_d(input logic [71:0] v, input int k);
      lane_d = (k < 4) ? v[8*k +: 8] : v[36+8*(k-4) +: 8];
   endfunction
   function automatic logic lane_c(input logic [71:0] v, input int k);
      lane_c = (k < 4) ? v[32+k] : v[64+k];
   endfunction
   function automatic cptx_kind_t kind_of(input logic [71:0] v);
      logic [7:0] c;
      logic all_idle;
      c = '0;
      all_idle = 1'b1;
      for (int k = 0; k < 8; k++) begin
         c[k] = lane_c(v, k);
         if (lane_d(v, k) != `CPTX_CH_IDLE) all_idle = 1'b0;
      end
      if (c == 8'h00) kind_of = CPTX_K_DATA;
      else if (c == 8'h01 && lane_d(v, 0) == `CPTX_CH_START) kind_of = CPTX_K_START;
      else if (c == 8'hFF && all_idle) kind_of = CPTX_K_IDLE;
      else kind_of = CPTX_K_TERM;
   endfunction
   // 64B/66B payload with bit <0> of the header dropped: bit 0 is the single sync bit
   function automatic logic [64:0] encode(input logic [71:0] v, input logic bad);
      logic [63:0] p;
      logic [7:0] ty;
      int t;
      p = '0;
      t = 8;
      for (int k = 7; k >= 0; k--) begin
         if (lane_c(v, k) && lane_d(v, k) == `CPTX_CH_TERM) t = k;
      end
      encode = {p, 1'b0};
      if (bad) begin
         for (int k = 0; k < 8; k++) p[8+7*k +: 7] = `CPTX_ERR_CODE;
         p[7:0] = `CPTX_TYPE_IDLE;
         encode = {p, 1'b0};
      end else begin
         case (kind_of(v))
            CPTX_K_DATA: begin
               for (int k = 0; k < 8; k++) p[8*k +: 8] = lane_d(v, k);
               encode = {p, 1'b1};
            end
            CPTX_K_IDLE: encode = {56'h0, `CPTX_TYPE_IDLE, 1'b0};
            CPTX_K_START: begin
               for (int k = 1; k < 8; k++) p[8*k +: 8] = lane_d(v, k);
               p[7:0] = `CPTX_TYPE_START;
               encode = {p, 1'b0};
            end
            default: begin
               case (t)
                  0: ty = 8'h87;
                  1: ty = 8'h99;
                  2: ty = 8'hAA;
                  3: ty = 8'hB4;
                  4: ty = 8'hCC;
                  5: ty = 8'hD2;
                  6: ty = 8'hE1;
                  default: ty = 8'hFF;
               endcase
               for (int k = 0; k < 7; k++) begin
                  if (k < t) p[8+8*k +: 8] = lane_d(v, k);
               end
               p[7:0] = ty;
               encode = {p, 1'b0};
            end
         endcase
      end
   endfunction
   // serial shift register, first bit of the block first, no inversion
   function automatic logic [39:0] crc_step(input logic [39:0] s, input logic [64:0] b);
      logic fb;
      crc_step = s;
      for (int i = 0; i < 65; i++) begin
         fb = crc_step[39] ^ b[i];
         crc_step = {crc_step[38:0], 1'b0} ^ (fb ? `CPTX_CRC_POLY : 40'h0);
      end
   endfunction

   // software-visible settings
   logic sub_mode_reg;
   cptx_code_t code_sel_reg;
   logic [15:0] line_rate_reg;
   logic [15:0] burst_end_idle_threshold;
   logic div_go_reg;
   cptx_div_state_t div_state_reg;
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sub_mode_reg <= 1'b0;
         code_sel_reg <= CPTX_CODE_LONG;
         line_rate_reg <= `CPTX_RATE_RST;
         burst_end_idle_threshold <= `CPTX_BURST_RST;
         div_go_reg <= 1'b1;
      end else if (clk_en_i) begin
         // a rate written mid-computation stays pending until the divider is free
         if (div_state_reg == CPTX_DIV_IDLE) div_go_reg <= 1'b0;
         if (reg_wr_i) begin
            case (reg_addr_i)
               `CPTX_OFS_CTRL: begin
                  sub_mode_reg <= reg_wdata_i[`CPTX_CTRL_SUB_BIT];
                  case (reg_wdata_i[`CPTX_CTRL_CODE_LSB +: 2])
                     2'h1: code_sel_reg <= CPTX_CODE_MED;
                     2'h2: code_sel_reg <= CPTX_CODE_SHORT;
                     default: code_sel_reg <= CPTX_CODE_LONG;
                  endcase
               end
               `CPTX_OFS_RATE: begin
                  line_rate_reg <= reg_wdata_i[15:0];
                  div_go_reg <= 1'b1;
               end
               `CPTX_OFS_BURST: burst_end_idle_threshold <= reg_wdata_i[15:0];
               default: ;
            endcase
         end
      end
   end

   // quota = floor(N/D), N = (65*host-64*line)*(220*65+1840) + 1840*64*line, D = 4160*line
   logic [47:0] num_w;
   logic [47:0] den_w;
   logic [47:0] coding_layer_rate;
   always_comb begin
      coding_layer_rate = 48'({line_rate_reg, 6'h00});
      num_w = 48'((48'(`CPTX_HOST_RATE_MBPS) * 48'd65 - coding_layer_rate)
         * (48'(`CPTX_PAY_VECTORS) * 48'(`CPTX_PAR_DEN) + 48'(`CPTX_PAR_NUM))
         + 48'(`CPTX_PAR_NUM) * coding_layer_rate);
      den_w = 48'(coding_layer_rate * 48'd65);
   end
   logic [5:0] div_cnt_reg;
   logic [47:0] div_num_reg;
   logic [47:0] div_rem_reg;
   logic [47:0] div_quo_reg;
   logic [47:0] div_rem_next;
   logic [15:0] overhead_removal_quota;
   logic [47:0] overhead_quota_fraction;
   logic [47:0] quota_den_reg;
   always_comb div_rem_next = {div_rem_reg[46:0], div_num_reg[47]};
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_state_reg <= CPTX_DIV_IDLE;
         div_cnt_reg <= '0;
         div_num_reg <= '0;
         div_rem_reg <= '0;
         div_quo_reg <= '0;
         overhead_removal_quota <= '0;
         overhead_quota_fraction <= '0;
         quota_den_reg <= 48'h1;
      end else if (clk_en_i) begin
         case (div_state_reg)
            CPTX_DIV_IDLE: begin
               if (div_go_reg) begin
                  div_state_reg <= CPTX_DIV_RUN;
                  div_cnt_reg <= '0;
                  div_num_reg <= num_w;
                  div_rem_reg <= '0;
                  div_quo_reg <= '0;
                  quota_den_reg <= (den_w == 48'h0) ? 48'h1 : den_w;
               end
            end
            CPTX_DIV_RUN: begin
               div_num_reg <= {div_num_reg[46:0], 1'b0};
               if (div_rem_next >= quota_den_reg) begin
                  div_rem_reg <= div_rem_next - quota_den_reg;
                  div_quo_reg <= {div_quo_reg[46:0], 1'b1};
               end else begin
                  div_rem_reg <= div_rem_next;
                  div_quo_reg <= {div_quo_reg[46:0], 1'b0};
               end
               div_cnt_reg <= div_cnt_reg + 6'h1;
               if (div_cnt_reg == `CPTX_DIV_STEPS - 6'h1) begin
                  div_state_reg <= CPTX_DIV_IDLE;
                  overhead_removal_quota <= (div_rem_next >= quota_den_reg) ?
                     16'({div_quo_reg[46:0], 1'b1}) : 16'({div_quo_reg[46:0], 1'b0});
                  overhead_quota_fraction <= (div_rem_next >= quota_den_reg) ?
                     div_rem_next - quota_den_reg : div_rem_next;
               end
            end
            default: div_state_reg <= CPTX_DIV_IDLE;
         endcase
      end
   end

   // idle deletion, one group per 220 passed vectors
   logic [15:0] pending_removal_tally;
   logic [15:0] parity_gap_removal_tally;
   logic [15:0] rate_gap_removal_tally;
   logic [15:0] parity_gap_idle_tally;
   logic [15:0] rate_gap_idle_tally;
   logic [15:0] parity_gap_sent_tally;
   logic [15:0] rate_gap_sent_tally;
   logic [47:0] fraction_accumulator;
   logic [7:0] parity_frac_acc_reg;
   logic [15:0] group_sent_reg;
   logic is_ctl;
   logic drop;
   logic group_end;
   logic quota_round_up_bit;
   logic par_round_bit;
   logic [15:0] total_quota;
   logic [15:0] par_quota;
   always_comb begin
      is_ctl = &{raw_vec_i[71:68], raw_vec_i[35:32]};
      quota_round_up_bit = (fraction_accumulator + overhead_quota_fraction) >= quota_den_reg;
      par_round_bit = (parity_frac_acc_reg + `CPTX_PAR_FRAC) >= 8'(`CPTX_PAR_DEN);
      total_quota = overhead_removal_quota + {15'h0, quota_round_up_bit};
      par_quota = `CPTX_PAR_INT + {15'h0, par_round_bit};
      if (!sub_mode_reg) begin
         drop = is_ctl && pending_removal_tally != 16'h0;
      end else begin
         drop = is_ctl && (rate_gap_removal_tally != 16'h0 || parity_gap_removal_tally != 16'h0);
      end
      group_end = !drop && group_sent_reg == `CPTX_PAY_VECTORS - 16'h1;
   end
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pending_removal_tally <= '0;
         parity_gap_removal_tally <= '0;
         rate_gap_removal_tally <= '0;
         fraction_accumulator <= '0;
         parity_frac_acc_reg <= '0;
         group_sent_reg <= '0;
      end else if (clk_en_i && raw_valid_i) begin
         group_sent_reg <= group_end ? 16'h0 : group_sent_reg + {15'h0, !drop};
         if (group_end) begin
            fraction_accumulator <= quota_round_up_bit ?
               fraction_accumulator + overhead_quota_fraction - quota_den_reg :
               fraction_accumulator + overhead_quota_fraction;
            parity_frac_acc_reg <= par_round_bit ? parity_frac_acc_reg + `CPTX_PAR_FRAC - 8'(`CPTX_PAR_DEN) :
               parity_frac_acc_reg + `CPTX_PAR_FRAC;
            pending_removal_tally <= pending_removal_tally + total_quota;
            parity_gap_removal_tally <= parity_gap_removal_tally + par_quota;
            rate_gap_removal_tally <= rate_gap_removal_tally
               + ((total_quota > par_quota) ? total_quota - par_quota : 16'h0);
         end else if (drop) begin
            if (!sub_mode_reg) begin
               pending_removal_tally <= pending_removal_tally - 16'h1;
            end else if (rate_gap_removal_tally != 16'h0) begin
               rate_gap_removal_tally <= rate_gap_removal_tally - 16'h1;
            end else begin
               parity_gap_removal_tally <= parity_gap_removal_tally - 16'h1;
            end
         end
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         parity_gap_idle_tally <= '0;
         rate_gap_idle_tally <= '0;
         parity_gap_sent_tally <= '0;
         rate_gap_sent_tally <= '0;
      end else if (clk_en_i && raw_valid_i && sub_mode_reg) begin
         if (is_ctl) begin
            if (rate_gap_removal_tally != 16'h0) rate_gap_idle_tally <= rate_gap_idle_tally + 16'h1;
            else parity_gap_idle_tally <= parity_gap_idle_tally + 16'h1;
         end
         if (!drop) begin
            rate_gap_sent_tally <= rate_gap_sent_tally + 16'h1;
            parity_gap_sent_tally <= parity_gap_sent_tally + 16'h1;
         end
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         raw_out_o <= '0;
         raw_out_valid_o <= 1'b0;
         begin_o <= 1'b1;
      end else if (clk_en_i) begin
         raw_out_valid_o <= raw_valid_i && !drop;
         if (raw_valid_i && !drop) raw_out_o <= raw_vec_i;
         if (raw_valid_i) begin_o <= 1'b0;
      end
   end

   // block encoder and forty bit check
   cptx_enc_state_t enc_state_reg;
   cptx_kind_t enc_kind;
   logic enc_bad;
   logic [64:0] enc_blk;
   logic [7:0] blk_cnt_reg;
   logic [7:0] blk_last;
   logic [39:0] crc_reg;
   logic [39:0] crc_next;
   logic [15:0] idle_run_reg;
   cptx_code_t code_eff;
   always_comb begin
      enc_kind = kind_of(raw_out_o);
      case (enc_state_reg)
         CPTX_ENC_CTL: enc_bad = enc_kind == CPTX_K_DATA || enc_kind == CPTX_K_TERM;
         CPTX_ENC_DATA: enc_bad = enc_kind == CPTX_K_START || enc_kind == CPTX_K_IDLE;
         default: enc_bad = 1'b1;
      endcase
      enc_blk = encode(raw_out_o, enc_bad);
      code_eff = sub_mode_reg ? code_sel_reg : CPTX_CODE_LONG;
      case (code_eff)
         CPTX_CODE_MED: blk_last = `CPTX_BLK_MED - 8'h1;
         CPTX_CODE_SHORT: blk_last = `CPTX_BLK_SHORT - 8'h1;
         default: blk_last = `CPTX_BLK_LONG - 8'h1;
      endcase
      crc_next = crc_step((blk_cnt_reg == 8'h0) ? 40'h0 : crc_reg, enc_blk);
   end
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         enc_state_reg <= CPTX_ENC_CTL;
         blk_cnt_reg <= '0;
         crc_reg <= '0;
         block_o <= '0;
         block_valid_o <= 1'b0;
         codeword_start_o <= 1'b0;
         check_o <= '0;
         check_valid_o <= 1'b0;
      end else if (clk_en_i) begin
         block_valid_o <= raw_out_valid_o;
         codeword_start_o <= raw_out_valid_o && blk_cnt_reg == 8'h0;
         check_valid_o <= 1'b0;
         if (raw_out_valid_o) begin
            block_o <= enc_blk;
            crc_reg <= crc_next;
            if (enc_bad) enc_state_reg <= CPTX_ENC_CTL;
            else if (enc_kind == CPTX_K_START) enc_state_reg <= CPTX_ENC_DATA;
            else if (enc_kind == CPTX_K_TERM) enc_state_reg <= CPTX_ENC_CTL;
            if (blk_cnt_reg >= blk_last) begin
               blk_cnt_reg <= 8'h0;
               check_o <= crc_next;
               check_valid_o <= 1'b1;
            end else begin
               blk_cnt_reg <= blk_cnt_reg + 8'h1;
            end
         end
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pad_bits_o <= `CPTX_PAD_LONG;
         parity_bits_o <= `CPTX_PARITY_LONG;
         idle_run_reg <= '0;
         burst_end_o <= 1'b0;
      end else if (clk_en_i) begin
         case (code_eff)
            CPTX_CODE_MED: begin
               pad_bits_o <= `CPTX_PAD_MED;
               parity_bits_o <= `CPTX_PARITY_MED;
            end
            CPTX_CODE_SHORT: begin
               pad_bits_o <= `CPTX_PAD_SHORT;
               parity_bits_o <= `CPTX_PARITY_SHORT;
            end
            default: begin
               pad_bits_o <= `CPTX_PAD_LONG;
               parity_bits_o <= `CPTX_PARITY_LONG;
            end
         endcase
         burst_end_o <= 1'b0;
         if (raw_out_valid_o && sub_mode_reg) begin
            if (enc_kind != CPTX_K_IDLE) begin
               idle_run_reg <= 16'h0;
            end else if (idle_run_reg != 16'hFFFF) begin
               idle_run_reg <= idle_run_reg + 16'h1;
               burst_end_o <= idle_run_reg + 16'h1 == burst_end_idle_threshold;
            end
         end
      end
   end

   // read port, data in the cycle after the strobe
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= '0;
      end else if (clk_en_i) begin
         reg_rdata_o <= '0;
         if (reg_rd_i) begin
            case (reg_addr_i)
               `CPTX_OFS_CTRL: reg_rdata_o <= {29'h0, code_sel_reg, sub_mode_reg};
               `CPTX_OFS_RATE: reg_rdata_o <= {16'h0, line_rate_reg};
               `CPTX_OFS_BURST: reg_rdata_o <= {16'h0, burst_end_idle_threshold};
               `CPTX_OFS_QUOTA: reg_rdata_o <= {15'h0, div_state_reg == CPTX_DIV_RUN || div_go_reg,
                  overhead_removal_quota};
               `CPTX_OFS_TALLY: reg_rdata_o <= {rate_gap_removal_tally, pending_removal_tally};
               `CPTX_OFS_SUBTALLY: reg_rdata_o <= {rate_gap_idle_tally, parity_gap_idle_tally};
               default: reg_rdata_o <= 32'h0;
            endcase
         end
      end
   end
   // head-end parity delay line depth, ceil((1800+40)/65)
   localparam int PARITY_DELAY_BLOCKS = DELAY_LINE_BLOCKS;
endmodule

// [hw/cptx_params.svh]
// constants of the coax transmit coding path
`ifndef CPTX_PARAMS_SVH
`define CPTX_PARAMS_SVH
`define CPTX_OFS_CTRL 8'h00
`define CPTX_OFS_RATE 8'h04
`define CPTX_OFS_BURST 8'h08
`define CPTX_OFS_QUOTA 8'h0C
`define CPTX_OFS_TALLY 8'h10
`define CPTX_OFS_SUBTALLY 8'h14
`define CPTX_CTRL_SUB_BIT 0
`define CPTX_CTRL_CODE_LSB 1
`define CPTX_RATE_RST 16'h2710
`define CPTX_BURST_RST 16'h001D
`define CPTX_HOST_RATE_MBPS 32'h0000_2710
`define CPTX_PAY_VECTORS 16'h00DC
`define CPTX_PAR_NUM 32'h0000_0730
`define CPTX_PAR_DEN 32'h0000_0041
`define CPTX_PAR_INT 16'h001C
`define CPTX_PAR_FRAC 8'h14
`define CPTX_CRC_POLY 40'h00_0482_0009
`define CPTX_BLK_LONG 8'hDC
`define CPTX_BLK_MED 8'h4C
`define CPTX_BLK_SHORT 8'h0C
`define CPTX_PAD_LONG 8'h3C
`define CPTX_PAD_MED 8'h3C
`define CPTX_PAD_SHORT 8'h14
`define CPTX_PARITY_LONG 12'h708
`define CPTX_PARITY_MED 12'h384
`define CPTX_PARITY_SHORT 12'h118
`define CPTX_DIV_STEPS 6'h30
`define CPTX_CH_IDLE 8'h07
`define CPTX_CH_START 8'hFB
`define CPTX_CH_TERM 8'hFD
`define CPTX_TYPE_IDLE 8'h1E
`define CPTX_TYPE_START 8'h78
`define CPTX_ERR_CODE 7'h1E
`endif

// [hw/cptx_pkg.sv]
// types of the coax transmit coding path
package cptx_pkg;
   typedef enum logic [1:0] {CPTX_CODE_LONG, CPTX_CODE_MED, CPTX_CODE_SHORT} cptx_code_t;
   typedef enum logic [1:0] {CPTX_K_DATA, CPTX_K_IDLE, CPTX_K_START, CPTX_K_TERM} cptx_kind_t;
   typedef enum logic {CPTX_ENC_CTL, CPTX_ENC_DATA} cptx_enc_state_t;
   typedef enum logic {CPTX_DIV_IDLE, CPTX_DIV_RUN} cptx_div_state_t;
endpackage

// [test/cptx_top_monitor.sv]
// assertion checker for the coax transmit coding path ports
`timescale 1ns/1ps
module cptx_top_monitor (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic clk_en_i,
   input wire logic [71:0] raw_vec_i,
   input wire logic raw_valid_i,
   input wire logic [71:0] raw_out_o,
   input wire logic raw_out_valid_o,
   input wire logic [64:0] block_o,
   input wire logic block_valid_o,
   input wire logic codeword_start_o,
   input wire logic check_valid_o,
   input wire logic [7:0] pad_bits_o,
   input wire logic [11:0] parity_bits_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   sequence taken_s;
      raw_valid_i && clk_en_i;
   endsequence
   sequence kept_s;
      raw_out_valid_o;
   endsequence
   chk_kept_cause: assert property (kept_s |-> $past(raw_valid_i && clk_en_i))
      else $error("kept vector without an input vector");
   chk_raw_layout: assert property (taken_s ##1 kept_s |-> raw_out_o == $past(raw_vec_i))
      else $error("kept vector differs from input");
   chk_block_after: assert property (kept_s |=> block_valid_o)
      else $error("kept vector gave no block");
   chk_block_cause: assert property (block_valid_o |-> $past(raw_out_valid_o))
      else $error("block without a kept vector");
   chk_data_payload: assert property (block_valid_o && block_o[0] |->
      block_o[64:1] == {$past(raw_out_o[67:36]), $past(raw_out_o[31:0])})
      else $error("data block payload altered");
   chk_data_sync: assert property (block_valid_o && block_o[0] |->
      $past(raw_out_o[35:32]) == 4'h0 && $past(raw_out_o[71:68]) == 4'h0)
      else $error("data sync bit on a control vector");
   chk_check_last: assert property (check_valid_o |-> block_valid_o)
      else $error("check pulse without a block");
   chk_start_block: assert property (codeword_start_o |-> block_valid_o)
      else $error("codeword start without a block");
   chk_code_sizes: assert property ((parity_bits_o == 12'h118) == (pad_bits_o == 8'h14))
      else $error("padding and parity sizes disagree");
endmodule
bind cptx_top cptx_top_monitor mon_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
   .raw_vec_i(raw_vec_i), .raw_valid_i(raw_valid_i), .raw_out_o(raw_out_o), .raw_out_valid_o(raw_out_valid_o),
   .block_o(block_o), .block_valid_o(block_valid_o), .codeword_start_o(codeword_start_o),
   .check_valid_o(check_valid_o), .pad_bits_o(pad_bits_o), .parity_bits_o(parity_bits_o));

// [test/cptx_mac_model.sv]
// host-side source of two-transfer vectors
`timescale 1ns/1ps
module cptx_mac_model (
   input wire logic clk_sys_i,
   output logic [71:0] raw_vec_o,
   output logic raw_valid_o
);
   initial begin
      raw_vec_o = 72'h0;
      raw_valid_o = 1'b0;
   end
   task automatic send(input logic [71:0] v);
      @(posedge clk_sys_i);
      raw_vec_o <= v;
      raw_valid_o <= 1'b1;
   endtask
   // unqualified cycles alternate between the inverse of the last word and the last word
   task automatic pause(input int n);
      repeat (n) begin
         @(posedge clk_sys_i);
         raw_vec_o <= ~raw_vec_o;
         raw_valid_o <= 1'b0;
      end
   endtask
endmodule

// [test/cptx_top_test.sv]
// self-checking bench for the coax transmit coding path
`timescale 1ns/1ps
`include "cptx_params.svh"
module cptx_top_test;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, rdata, rv;
   logic reg_wr = 1'b0, reg_rd = 1'b0, clk_en = 1'b1;
   logic [71:0] raw_vec, raw_out;
   logic raw_valid, raw_out_valid, block_valid, cw_start, check_valid, burst_end, begin_flag;
   logic [64:0] block, eb;
   logic [39:0] check, crc;
   logic [7:0] pad;
   logic [11:0] parity;
   logic [71:0] rq[$];
   logic [64:0] bq[$];
   int failures = 0, checks = 0, cycles = 0, bursts = 0, blk_n = 0, cw_len = 220, r;
   localparam logic [71:0] IDLE_V = {4'hF, 32'h0707_0707, 4'hF, 32'h0707_0707};
   initial forever #20 clk_sys_i = ~clk_sys_i;
   cptx_top #(.DELAY_LINE_BLOCKS(29)) dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en),
      .raw_vec_i(raw_vec), .raw_valid_i(raw_valid), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .raw_out_o(raw_out),
      .raw_out_valid_o(raw_out_valid), .block_o(block), .block_valid_o(block_valid),
      .codeword_start_o(cw_start), .check_o(check), .check_valid_o(check_valid), .pad_bits_o(pad),
      .parity_bits_o(parity), .burst_end_o(burst_end), .begin_o(begin_flag));
   cptx_mac_model mac_u (.clk_sys_i(clk_sys_i), .raw_vec_o(raw_vec), .raw_valid_o(raw_valid));
   task automatic check_eq(input logic [71:0] seen, input logic [71:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("counts: %0d checks, %0d failures", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys_i);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd <= 1'b0;
      #1 d = rdata;
   endtask
   // polls until the quota computation reports idle
   task automatic quota_read(output logic [31:0] d);
      d = 32'h0001_0000;
      for (int i = 0; i < 100 && d[16]; i++) reg_read(`CPTX_OFS_QUOTA, d);
   endtask
   task automatic do_reset();
      @(posedge clk_sys_i);
      rst_b_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      blk_n = 0;
      bursts = 0;
      rq.delete();
      bq.delete();
      @(negedge clk_sys_i);
   endtask
   // host 10000 Mb/s, payload 220 vectors, parity 1840/65 vectors, coding rate r*64/65
   function automatic logic [15:0] quota_f(input longint r);
      return ((650000 - 64 * r) * 16140 + 117760 * r) / (4160 * r);
   endfunction
   function automatic logic [39:0] crc_f(input logic [39:0] c, input logic [64:0] b);
      for (int i = 0; i < 65; i++) c = {c[38:0], 1'b0} ^ ((b[i] ^ c[39]) ? `CPTX_CRC_POLY : 40'h0);
      return c;
   endfunction
   function automatic logic [64:0] exp_blk(input logic [71:0] v);
      if (v[71:68] == 4'hF && v[35:32] == 4'h0) return {24'h0, v[31:0], 8'hCC, 1'b0};
      if (v[35:32] == 4'h0) return {v[67:36], v[31:0], 1'b1};
      if (v[35:32] == 4'h1) return {v[67:36], v[31:8], 8'h78, 1'b0};
      return {56'h0, 8'h1E, 1'b0};
   endfunction
   function automatic logic [71:0] rnd_vec(input int st);
      logic [31:0] a = $urandom;
      logic [31:0] b = $urandom;
      if (st == 2) return {4'hF, 32'h0707_07FD, 4'h0, a};
      return st ? {4'h0, b, 4'h1, a[31:8], 8'hFB} : {4'h0, b, 4'h0, a};
   endfunction
   task automatic put(input logic [71:0] v, input bit keep);
      if (keep) begin
         rq.push_back(v);
         bq.push_back(exp_blk(v));
      end
      mac_u.send(v);
   endtask
   always @(negedge clk_sys_i) begin
      if (raw_out_valid) check_eq(raw_out, rq.size() ? rq.pop_front() : 'x);
      if (block_valid) begin
         eb = bq.size() ? bq.pop_front() : 'x;
         check_eq(block, eb);
         check_eq(cw_start, blk_n == 0);
         crc = crc_f(blk_n == 0 ? 40'h0 : crc, eb);
         blk_n++;
         check_eq(check_valid, blk_n == cw_len);
         if (blk_n == cw_len) begin
            check_eq(check, crc);
            blk_n = 0;
         end
      end
      if (burst_end) bursts++;
      cycles++;
      if (cycles == 20000) begin
         failures++;
         close_out();
      end
   end
   initial begin
      void'($urandom(88699));
      do_reset();
      check_eq(begin_flag, 1'b1);
      check_eq(pad, 8'h3C);
      check_eq(parity, 12'h708);
      reg_read(`CPTX_OFS_RATE, rv);
      check_eq(rv, 32'h0000_2710);
      reg_read(`CPTX_OFS_BURST, rv);
      check_eq(rv, 32'h0000_001D);
      reg_write(8'h40, 32'hFFFF_FFFF);
      reg_read(8'h40, rv);
      check_eq(rv, 32'h0);
      $display("test reset_map done");
      for (int i = 0; i < 4; i++) begin
         r = i == 0 ? 5000 : i == 1 ? 10000 : 1000 + $urandom_range(9000);
         reg_write(`CPTX_OFS_RATE, r);
         quota_read(rv);
         check_eq(rv, quota_f(r));
      end
      $display("test quota_rates done");
      for (int m = 0; m < 4; m++) begin
         reg_write(`CPTX_OFS_CTRL, m == 3 ? 32'h4 : {m[1:0], 1'b1});
         repeat (2) @(negedge clk_sys_i);
         check_eq(pad, m == 2 ? 8'h14 : 8'h3C);
         check_eq(parity, m == 0 || m == 3 ? 12'h708 : m == 1 ? 12'h384 : 12'h118);
      end
      $display("test code_select done");
      do_reset();
      cw_len = 12;
      reg_write(`CPTX_OFS_CTRL, 32'h5);
      for (int i = 0; i < 24; i++) put(rnd_vec(i == 0 ? 1 : i == 23 ? 2 : 0), 1'b1);
      mac_u.pause(4);
      check_eq(begin_flag, 1'b0);
      check_eq(bq.size(), 0);
      $display("test short_codeword done");
      do_reset();
      cw_len = 220;
      reg_write(`CPTX_OFS_CTRL, 32'h1);
      reg_write(`CPTX_OFS_BURST, 32'h5);
      // a write while the enable is low must not land
      @(posedge clk_sys_i);
      clk_en <= 1'b0;
      reg_write(`CPTX_OFS_BURST, 32'h7);
      clk_en <= 1'b1;
      for (int i = 0; i < 8; i++) put(IDLE_V, 1'b1);
      mac_u.pause(4);
      check_eq(bursts, 1);
      reg_read(`CPTX_OFS_BURST, rv);
      check_eq(rv, 32'h0000_0005);
      reg_read(`CPTX_OFS_SUBTALLY, rv);
      check_eq(rv, 32'h0000_0008);
      $display("test burst_end done");
      do_reset();
      quota_read(rv);
      for (int i = 0; i < 220; i++) put(rnd_vec(i == 0), 1'b1);
      mac_u.pause(4);
      reg_read(`CPTX_OFS_TALLY, rv);
      check_eq(rv[15:0], quota_f(10000));
      for (int i = 0; i < 5; i++) put(IDLE_V, 1'b0);
      mac_u.pause(4);
      reg_read(`CPTX_OFS_TALLY, rv);
      check_eq(rv[15:0], quota_f(10000) - 16'h0005);
      check_eq(rq.size(), 0);
      $display("test long_codeword done");
      close_out();
   end
endmodule
